/* src/fps_pkg.sv */
package fps_pkg;
  // clock and pin timing
  localparam int CLK_NS = 4;                 // 250 MHz system clock
  localparam int T_ACC_NS = 100;             // random read access, least time
  localparam int T_WP_NS = 50;               // write strobe low width
  localparam int T_SETUP_NS = 10;            // address to strobe setup
  localparam int T_HIGH_NS = 30;             // strobes high between cycles
  localparam int SYNC_STAGES = 2;            // data input synchroniser depth
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HIGH_CYC = 8'((T_HIGH_NS + CLK_NS - 1) / CLK_NS);

  // flash pins
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;

  // status bit positions in a status read
  localparam int BIT_POLL = 7;               // polling_bit
  localparam int BIT_TOG1 = 6;               // toggle_bit_primary
  localparam int BIT_ERR = 5;                // error_flag
  localparam int BIT_TIMER = 3;              // erase_timer_flag
  localparam int BIT_TOG2 = 2;               // toggle_bit_secondary
  localparam logic [7:0] STATUS_MASK = 8'hEC; // reserved bits 0, 1 and 4 dropped

  // own register map (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_SUSP = 3;
  localparam int ST_TIMER = 4;
  localparam int ST_FAILBLK = 5;
  localparam int ST_REFUSED = 6;
  localparam int ST_SBYTE_LSB = 8;

  // operations written to the control register
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_DPOLL = 3'b010,
    OP_TPOLL = 3'b011,
    OP_ADDBLK = 3'b100
  } fps_op_t;

  localparam logic [2:0] OP_RESET = 3'b000;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
endpackage

/* src/fps_pin_cycle.sv */
`timescale 1ns/1ns
`default_nettype none
// one asynchronous read or write cycle on the flash pins
module fps_pin_cycle
  import fps_pkg::*;
(
  input wire logic clk,
  input wire logic srst_n,
  input wire logic req,
  input wire logic req_we,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic chip_en_n,
  output logic out_en_n,
  output logic wr_en_n,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe,
  input wire logic [DATA_W-1:0] dq_i
);
  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_SETUP = 2'b01,
    E_ACTIVE = 2'b10,
    E_RECOVER = 2'b11
  } fps_eng_t;

  fps_eng_t state_q;
  logic [7:0] cnt_q;              // cycles left in the current phase
  logic we_q;                     // current cycle is a write
  logic [DATA_W-1:0] sync1_q;     // first synchroniser stage
  logic [DATA_W-1:0] sync2_q;     // second stage, the only one read

  // data pins come from another timing world
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= dq_i;
      sync2_q <= sync1_q;
    end
  end

  // cycle sequencer; every pin is a flop
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_q <= E_IDLE;
      cnt_q <= 8'h00;
      we_q <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
      wr_en_n <= 1'b1;
      addr <= '0;
      dq_o <= '0;
      dq_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        E_IDLE: begin
          if (req) begin
            // address and chip enable first, strobe later
            we_q <= req_we;
            addr <= req_addr;
            dq_o <= req_wdata;
            dq_oe <= req_we;
            chip_en_n <= 1'b0;
            cnt_q <= SETUP_CYC - 8'h01;
            state_q <= E_SETUP;
          end
        end
        E_SETUP: begin
          if (cnt_q == 8'h00) begin
            // each read drops output enable afresh: one read cycle per pulse
            out_en_n <= we_q;
            wr_en_n <= ~we_q;
            cnt_q <= (we_q ? WP_CYC : ACC_CYC) - 8'h01;
            state_q <= E_ACTIVE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        E_ACTIVE: begin
          if (cnt_q == 8'h00) begin
            // access time plus synchroniser delay has passed
            if (!we_q) begin
              rdata <= sync2_q;
            end
            out_en_n <= 1'b1;
            wr_en_n <= 1'b1;
            chip_en_n <= 1'b1;
            cnt_q <= HIGH_CYC - 8'h01;
            state_q <= E_RECOVER;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        E_RECOVER: begin
          // data held past the strobe edge for write hold
          if (cnt_q == 8'h00) begin
            dq_oe <= 1'b0;
            done <= 1'b1;
            state_q <= E_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= E_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* src/fps_host.sv */
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - host masks reserved status bits 0,1,4
// - host polls programmed address or block
// - two equal reads mean done; reread
// - error flag on failure; retire block
// - add blocks only while timer zero
module fps_host
  import fps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic flash_chip_en_n,
  output logic flash_out_en_n,
  output logic flash_wr_en_n,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [DATA_W-1:0] flash_dq_i
);
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ISSUE = 2'b01,
    M_WAIT = 2'b10
  } fps_main_t;

  // reset release
  // two flops, so every register leaves reset on the same edge
  logic rst_meta_q;
  logic srst_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      srst_n <= rst_meta_q;
    end
  end

  // software registers and poll state
  logic [2:0] op_q;               // operation in progress
  logic [ADDR_W-1:0] addr_q;      // flash word address
  logic [DATA_W-1:0] data_q;      // write data, or last word written for polling
  logic [DATA_W-1:0] rd_q;        // last word read from the flash
  logic [DATA_W-1:0] prev_q;      // previous read of a toggle poll
  logic busy_q;
  logic done_q;
  logic fail_q;
  logic susp_q;                   // finished on a suspended erase block
  logic timer_q;                  // erase_timer_flag as last seen
  logic failblk_q;                // secondary toggle moved at the failing address
  logic refused_q;                // block add refused, erase already started
  logic err_seen_q;               // error flag seen, one confirming read pending
  logic final_q;                  // toggling stopped, final value read pending
  logic first_q;                  // no previous read yet in this toggle poll
  fps_main_t state_q;

  // bus side
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic start;
  logic eng_req;
  logic eng_done;
  logic [DATA_W-1:0] eng_rdata;

  // masked status byte of a read
  function automatic logic [7:0] status_byte(input logic [DATA_W-1:0] w);
    status_byte = w[7:0] & STATUS_MASK;
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [31:0] st);
    case (a)
      REG_CTRL: reg_read = {29'h0000_0000, op_q};
      REG_ADDR: reg_read = {13'h0000, addr_q};
      REG_DATA: reg_read = {16'h0000, data_q};
      REG_STAT: reg_read = st;
      REG_RDATA: reg_read = {16'h0000, rd_q};
      default: reg_read = 32'h0000_0000;
    endcase
  endfunction

  // status word: flags in the low byte, masked status byte above them
  logic [31:0] stat_word;
  assign stat_word = {16'h0000, status_byte(rd_q), 1'b0, refused_q, failblk_q, timer_q,
                      susp_q, fail_q, done_q, busy_q};

  // a control write while idle starts an operation; ignored while busy
  assign start = wr_pend_q && (wr_addr_q == REG_CTRL) && !busy_q;

  // ahb-lite slave: zero wait states, always okay
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= STAT_RESET;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      // no wait states: every transfer is answered on the next edge
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        wr_pend_q <= hwrite;
        wr_addr_q <= {haddr[7:2], 2'b00};
        if (!hwrite) begin
          // read data stands during the data phase
          hrdata <= reg_read({haddr[7:2], 2'b00}, stat_word);
        end
      end
    end
  end

  // address and data registers, frozen while busy
  // a write while busy is dropped with no bus sign, so software must poll busy first
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      addr_q <= '0;
      data_q <= '0;
      op_q <= OP_RESET;
    end else if (wr_pend_q && !busy_q) begin
      case (wr_addr_q)
        REG_ADDR: addr_q <= hwdata[ADDR_W-1:0];
        REG_DATA: data_q <= hwdata[DATA_W-1:0];
        REG_CTRL: op_q <= hwdata[2:0];
        default: begin
        end
      endcase
    end
  end

  // operation sequencer and status evaluation
  // a toggle poll needs one reference read before it can compare two reads
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      state_q <= M_IDLE;
      eng_req <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      susp_q <= 1'b0;
      timer_q <= 1'b0;
      failblk_q <= 1'b0;
      refused_q <= 1'b0;
      err_seen_q <= 1'b0;
      final_q <= 1'b0;
      first_q <= 1'b0;
      rd_q <= '0;
      prev_q <= '0;
    end else begin
      eng_req <= 1'b0;
      case (state_q)
        M_IDLE: begin
          if (start) begin
            // software starts a poll only once the command sequence is in
            busy_q <= 1'b1;
            done_q <= 1'b0;
            fail_q <= 1'b0;
            susp_q <= 1'b0;
            failblk_q <= 1'b0;
            refused_q <= 1'b0;
            err_seen_q <= 1'b0;
            final_q <= 1'b0;
            first_q <= 1'b1;
            if (hwdata[2:0] == OP_ADDBLK && timer_q) begin
              // erase has begun: only suspend may be written now
              refused_q <= 1'b1;
              busy_q <= 1'b0;
              done_q <= 1'b1;
            end else begin
              state_q <= M_ISSUE;
            end
          end
        end
        M_ISSUE: begin
          // one request pulse per flash cycle
          eng_req <= 1'b1;
          state_q <= M_WAIT;
        end
        M_WAIT: begin
          if (eng_done) begin
            state_q <= M_ISSUE;
            first_q <= 1'b0;
            // every poll read also refreshes the erase timer view
            if (op_q == OP_DPOLL || op_q == OP_TPOLL) begin
              rd_q <= eng_rdata;
              timer_q <= eng_rdata[BIT_TIMER];
            end else if (op_q == OP_READ) begin
              // idle bank reads hand the array word back unchanged
              rd_q <= eng_rdata;
            end
            case (op_q)
              OP_DPOLL: begin
                // match means the operation ended; suspended block also reads one
                if (eng_rdata[BIT_POLL] == data_q[BIT_POLL]) begin
                  state_q <= M_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                end else if (err_seen_q) begin
                  // still no match after the error flag: block is bad
                  state_q <= M_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  fail_q <= 1'b1;
                end else if (eng_rdata[BIT_ERR]) begin
                  // the flag may rise with a late match, so read once more
                  err_seen_q <= 1'b1;
                end
              end
              OP_TPOLL: begin
                prev_q <= eng_rdata;
                if (first_q) begin
                  // need a reference read first
                end else if (final_q) begin
                  // the read after two equal ones carries the final value
                  state_q <= M_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                end else if (eng_rdata[BIT_TOG1] == prev_q[BIT_TOG1]) begin
                  final_q <= 1'b1;
                  // primary steady but secondary moving: suspended erase block
                  susp_q <= eng_rdata[BIT_TOG2] ^ prev_q[BIT_TOG2];
                end else if (err_seen_q) begin
                  // still toggling after the error flag: failed
                  state_q <= M_IDLE;
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  fail_q <= 1'b1;
                  failblk_q <= eng_rdata[BIT_TOG2] ^ prev_q[BIT_TOG2];
                end else if (eng_rdata[BIT_ERR]) begin
                  err_seen_q <= 1'b1;
                end
              end
              default: begin
                // single read, write or block add ends after one cycle
                // the engine reports done only after its recovery gap
                state_q <= M_IDLE;
                busy_q <= 1'b0;
                done_q <= 1'b1;
              end
            endcase
          end
        end
        default: begin
          state_q <= M_IDLE;
        end
      endcase
    end
  end

  // pin cycle engine; writes carry the data register
  // the engine holds address and data until its recovery ends
  fps_pin_cycle fps_pin_cycle_inst (
    .clk(clk),
    .srst_n(srst_n),
    .req(eng_req),
    .req_we(op_q == OP_WRITE || op_q == OP_ADDBLK),
    .req_addr(addr_q),
    .req_wdata(data_q),
    .done(eng_done),
    .rdata(eng_rdata),
    .chip_en_n(flash_chip_en_n),
    .out_en_n(flash_out_en_n),
    .wr_en_n(flash_wr_en_n),
    .addr(flash_addr),
    .dq_o(flash_dq_o),
    .dq_oe(flash_dq_oe),
    .dq_i(flash_dq_i)
  );

  // hsize is not checked: only whole words are used
  // upper address bits and upper write data bits are don't care
  logic unused_ok;
  assign unused_ok = ^{hsize, haddr[31:8], haddr[1:0], hwdata[31:19]};
endmodule
`default_nettype wire

/* bench/fps_host_chk.sv */
`timescale 1ns/1ns
`default_nettype none
// bus and flash pin timing watch, ports of the host only
module fps_host_chk
  import fps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic flash_chip_en_n,
  input wire logic flash_out_en_n,
  input wire logic flash_wr_en_n,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // zero wait slave, never stretches once up
  ready_stays_a: assert property (hreadyout |=> hreadyout) else $error("ready dropped");
  okay_only_a: assert property (!hresp) else $error("error response seen");
  // unmapped places read as zero
  unmapped_zero_a: assert property (hsel && htrans[1] && hready && !hwrite && haddr > 32'h13
    && haddr < 32'h100 |=> hrdata == 32'h0) else $error("unmapped read not zero");
  // chip enable leads output enable by the setup time
  oe_setup_a: assert property ($fell(flash_out_en_n) |-> $past(flash_chip_en_n, 3) == 1'b0)
    else $error("oe without setup");
  one_strobe_a: assert property (!(!flash_out_en_n && !flash_wr_en_n)) else $error("both strobes low");
  // each read is one fresh oe pulse of the access length
  read_pulse_a: assert property ($fell(flash_out_en_n) |-> !flash_out_en_n[*8] ##20 $rose(flash_out_en_n))
    else $error("read pulse length wrong");
  addr_hold_a: assert property (!flash_chip_en_n && $past(flash_chip_en_n) == 1'b0 |-> $stable(flash_addr))
    else $error("address moved in cycle");
  // recovery gap before the next cycle
  recovery_gap_a: assert property ($rose(flash_chip_en_n) |-> flash_chip_en_n[*8]) else $error("recovery short");
  write_pulse_a: assert property ($fell(flash_wr_en_n) |-> ##13 $rose(flash_wr_en_n)) else $error("write pulse wrong");
  drive_write_a: assert property (flash_dq_oe |-> flash_out_en_n) else $error("drive during read");
endmodule
`default_nettype wire

/* bench/fps_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
// flash device: bank with addr msb set is the busy one, addr bit 17 picks the block
module fps_flash_model
  import fps_pkg::*;
(
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [2:0] mode,
  input wire logic [DATA_W-1:0] prog_word,
  input wire logic [DATA_W-1:0] arr_word,
  input wire logic [7:0] reads_left,
  output logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0] last_wr
);
  logic [2:0] st0 = 3'd0; // mode as last set
  logic [2:0] st; // bank state: 0 idle 1 prog 2 erase 3 susp 4 prog fail 5 erase fail
  int need = 0; // status reads before completion
  int nrd = 0; // status reads seen so far
  int mark = 0; // read count when the mode was set
  logic tog1 = 1'b0;
  logic tog2 = 1'b0;
  logic [7:0] sb; // status byte, reserved bits set to junk
  logic [DATA_W-1:0] fin = 16'hFFFF; // word left by a finished op
  logic [DATA_W-1:0] val;
  logic [DATA_W-1:0] held = 16'h0;
  logic busy;
  // a new mode restarts the per bank state
  always @(mode or reads_left) begin
    st0 = mode;
    need = reads_left;
    mark = nrd;
    fin = (mode == 3'd1) ? prog_word : 16'hFFFF;
  end
  // each read cycle of the busy bank (addr msb set) flips the toggles and is counted
  always @(negedge out_en_n) begin
    if (!chip_en_n && addr[18]) begin
      tog1 = ~tog1;
      tog2 = ~tog2;
      nrd++;
    end
  end
  always_comb begin
    // a running op ends on its last counted read; one writer per variable
    st = (nrd - mark >= need && (st0 == 3'd1 || st0 == 3'd2)) ? 3'd0 : st0;
    case (st)
      3'd1: sb = {~prog_word[7], tog1, 1'b0, 1'b1, 1'b0, 1'b1, 2'b11};
      3'd4: sb = {~prog_word[7], tog1, 1'b1, 1'b1, 1'b0, 1'b1, 2'b11};
      3'd2: sb = {1'b0, tog1, 1'b0, 1'b1, 1'b1, 1'b0, 2'b11};
      3'd3: sb = {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, tog2, 2'b11};
      default: sb = {1'b0, tog1, 1'b1, 1'b1, 1'b1, tog2, 2'b11};
    endcase
    // suspended bank outside its block reads stored data
    busy = addr[18] && st != 3'd0 && !(st == 3'd3 && !addr[17]);
    val = busy ? {8'h5A, sb} : ((addr[18] && st == 3'd0) ? fin : arr_word);
  end
  // released pins do not keep the last value
  always @(posedge out_en_n) held = val;
  assign dq_out = (chip_en_n || out_en_n) ? ~held : val;
  always @(posedge wr_en_n) last_wr = dq_in;
endmodule
`default_nettype wire

/* bench/tb_fps_host.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_fps_host;
  import fps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, ce_n, oe_n, we_n, dq_oe;
  logic [31:0] hrdata, rv;
  logic [ADDR_W-1:0] faddr;
  logic [DATA_W-1:0] dq_o, dq_i, last_wr;
  logic [2:0] mode = 3'h0;
  logic [DATA_W-1:0] pw = 16'h0080;
  logic [DATA_W-1:0] aw = 16'h3C3C;
  logic [7:0] nleft = 8'h0;
  int fails = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  fps_host fps_host_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .flash_chip_en_n(ce_n), .flash_out_en_n(oe_n),
    .flash_wr_en_n(we_n), .flash_addr(faddr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  fps_flash_model fps_flash_model_inst (.chip_en_n(ce_n), .out_en_n(oe_n), .wr_en_n(we_n),
    .addr(faddr), .dq_in(dq_o), .mode(mode), .prog_word(pw), .arr_word(aw), .reads_left(nleft),
    .dq_out(dq_i), .last_wr(last_wr));
  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // masked comparison of a word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    total_checks++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got & m, exp & m);
    end
  endtask
  // one ready sample, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        fails++;
        end_of_test();
      end
      @(posedge clk);
    end
  endtask
  // single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  // start an op at an address and wait until busy drops
  task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    ahb(1'b1, REG_ADDR, a, rv);
    ahb(1'b1, REG_DATA, wd, rv);
    ahb(1'b1, REG_CTRL, {29'h0, op}, rv);
    ahb(1'b0, REG_STAT, 32'h0, rv);
    ahb(1'b0, REG_STAT, 32'h0, rv);
    while (rv[ST_BUSY] !== 1'b0) begin
      n++;
      if (n > 2000) begin
        fails++;
        end_of_test();
      end
      ahb(1'b0, REG_STAT, 32'h0, rv);
    end
  endtask
  // pass through a dummy mode so the model always restarts
  task automatic setm(input logic [2:0] m, input logic [7:0] n);
    mode <= 3'h7;
    @(posedge clk);
    mode <= m;
    nleft <= n;
    @(posedge clk);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    ahb(1'b0, REG_STAT, 32'h0, rv);
    chk(rv, STAT_RESET, 32'hFFFFFFFF);
    ahb(1'b1, REG_STAT, 32'hFF, rv);
    ahb(1'b0, REG_STAT, 32'h0, rv);
    chk(rv, STAT_RESET, 32'hFFFFFFFF);
    ahb(1'b0, 8'h14, 32'h0, rv);
    chk(rv, 32'h0, 32'hFFFFFFFF);
    run(OP_WRITE, 32'h00060010, 32'h0000BEEF);
    chk({16'h0, last_wr}, 32'h0000BEEF, 32'hFFFF);
    chk({13'h0, faddr}, 32'h00060010, 32'h7FFFF);
    setm(3'd1, 8'd5);
    run(OP_READ, 32'h00000010, 32'h0);
    ahb(1'b0, REG_RDATA, 32'h0, rv);
    chk(rv, 32'h00003C3C, 32'hFFFF);
    run(OP_DPOLL, 32'h00060010, 32'h00000080);
    chk(rv, 32'h00008002, 32'hFF6F);
    ahb(1'b0, REG_RDATA, 32'h0, rv);
    chk(rv, 32'h00000080, 32'hFFFF);
    run(OP_ADDBLK, 32'h00060010, 32'h00000030);
    chk(rv, 32'h00000002, 32'h43);
    chk({16'h0, last_wr}, 32'h00000030, 32'hFFFF);
    setm(3'd2, 8'd4);
    run(OP_TPOLL, 32'h00060010, 32'h0);
    chk(rv, 32'h0000EC02, 32'hFF6F);
    ahb(1'b0, REG_RDATA, 32'h0, rv);
    chk(rv, 32'h0000FFFF, 32'hFFFF);
    run(OP_ADDBLK, 32'h00060010, 32'h0);
    chk(rv, 32'h00000040, 32'h40);
    setm(3'd3, 8'd0);
    run(OP_TPOLL, 32'h00060010, 32'h0);
    chk(rv, 32'h0000000A, 32'h6F);
    run(OP_DPOLL, 32'h00060010, 32'h00000080);
    chk(rv, 32'h00000002, 32'h6F);
    setm(3'd5, 8'd0);
    run(OP_TPOLL, 32'h00060010, 32'h0);
    chk(rv, 32'h00000024, 32'h25);
    setm(3'd4, 8'd0);
    run(OP_DPOLL, 32'h00060010, 32'h00000080);
    chk(rv, 32'h00000004, 32'h05);
    end_of_test();
  end
endmodule
bind fps_host fps_host_chk fps_host_chk_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .flash_chip_en_n(flash_chip_en_n), .flash_out_en_n(flash_out_en_n),
  .flash_wr_en_n(flash_wr_en_n), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe));
`default_nettype wire
